// ==== src/ccac_core.sv ====
// Current result, alert limit selection and alert flags.
// Assumes the converter engine, averaging and serial engine run on CLK.
`timescale 1ns/1ps

// How it works
// - Current result is sense result times calibration, as plain integers.
// - Averaged sense values from the engine are sampled, then scaled by calibration into the current result.
// - Current bit 15 is the sign; bits 14:0 are the low bits of the two's complement value.
// - Negative current is two's complement, top bit set.
// - Calibration keeps 15 bits; bit 15 always reads zero.
// - Calibration value scales current, and through it power.
// - Power step weighs twenty-five current steps.
// - Sense over limit select asserts alert when sense exceeds limit.
// - Sense under limit select asserts alert when sense is below limit.
// - Bus over limit select asserts alert when bus exceeds limit.
// - Bus under limit select asserts alert when bus is below limit.
// - Power over limit select asserts alert when power exceeds limit.
// - Selected result compares against the 16-bit alert limit.
// - With several selects set, only the highest one is compared.
// - Ready alert select asserts alert when conversion ready sets.
// - Alert source flag shows a limit caused the alert.
// - Latch mode clears alert source only on control register read.
// - Transparent mode clears alert source after a conversion without alert.
// - Latch bit zero is transparent, one latches pin and flag.
// - Conversion ready sets only after both multiplications finish.
// - Ready clears on config write except power down, and on control read.
// - Results stay readable and hold the latest completed conversion.
// - Overflow flag sets when an arithmetic step overflows.
// - Polarity zero makes alert active low, one active high.
module ccac_core (
	input wire logic CLK,
	input wire logic NRST,
	input wire ccac_pkg::ccac_req_s REQ,
	output logic [15:0] REG_RDATA,
	input wire logic CONV_DONE,
	input wire ccac_pkg::ccac_conv_s CONV,
	input wire logic [15:0] ALERT_LIMIT,
	input wire logic CFG_WR,
	input wire logic CFG_POWER_DOWN,
	output logic [15:0] POWER_RESULT,
	output logic ALERT_O,
	output logic ALERT_OE
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		ccac_pkg::ccac_state_e st;
		ccac_pkg::ccac_conv_s smp;
		logic [14:0] calib;
		logic [5:0] sel;
		logic polarity;
		logic latch;
		logic alert_src;
		logic conv_ready;
		logic overflow;
		logic cur_ovf;
		logic [15:0] current;
		logic [15:0] power;
		logic [15:0] rdata;
		logic alert_oe;
	} ccac_regs_s;

	ccac_regs_s s_q;
	ccac_regs_s s_d;

	logic signed [31:0] cur_prod;
	logic [31:0] pwr_prod;
	logic [31:0] pwr_quot;
	logic [15:0] cur_mag;
	logic limit_hit;
	logic ctl_read;
	logic [15:0] ctl_word;

	function automatic logic [15:0] abs16(input logic [15:0] v);
		abs16 = v[15] ? 16'(~v + 16'h0001) : v;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		cur_prod = $signed(s_q.smp.sense) * $signed({1'b0, s_q.calib});
		cur_mag = abs16(s_q.current);
		pwr_prod = {16'h0000, cur_mag} * {16'h0000, s_q.smp.bus};
		pwr_quot = pwr_prod / 32'(ccac_pkg::POWER_DIV);
		limit_hit = 1'b0;
		ctl_read = REQ.rd && (REQ.addr == ccac_pkg::ADDR_ALERT_CTL);
		ctl_word = 16'h0000;
		ctl_word[15:10] = s_q.sel;
		ctl_word[ccac_pkg::POS_ALERT_SRC] = s_q.alert_src;
		ctl_word[ccac_pkg::POS_CONV_READY] = s_q.conv_ready;
		ctl_word[ccac_pkg::POS_OVERFLOW] = s_q.overflow;
		ctl_word[ccac_pkg::POS_POLARITY] = s_q.polarity;
		ctl_word[ccac_pkg::POS_LATCH] = s_q.latch;

		// Read data taken from flags before any read clear
		if (REQ.rd) begin
			if (REQ.addr == ccac_pkg::ADDR_CURRENT) begin
				s_d.rdata = s_q.current;
			end else if (REQ.addr == ccac_pkg::ADDR_CALIB) begin
				s_d.rdata = {1'b0, s_q.calib};
			end else if (REQ.addr == ccac_pkg::ADDR_ALERT_CTL) begin
				s_d.rdata = ctl_word;
			end else begin
				s_d.rdata = 16'h0000;
			end
		end

		if (REQ.wr) begin
			if (REQ.addr == ccac_pkg::ADDR_CALIB) begin
				s_d.calib = REQ.wdata[14:0];
			end else if (REQ.addr == ccac_pkg::ADDR_ALERT_CTL) begin
				s_d.sel = REQ.wdata[15:10];
				s_d.polarity = REQ.wdata[ccac_pkg::POS_POLARITY];
				s_d.latch = REQ.wdata[ccac_pkg::POS_LATCH];
			end
		end

		// Clears first, so a set below wins in the same cycle
		if (ctl_read) begin
			s_d.conv_ready = 1'b0;
			if (s_q.latch) begin
				s_d.alert_src = 1'b0;
			end
		end
		if (CFG_WR && !CFG_POWER_DOWN) begin
			s_d.conv_ready = 1'b0;
		end

		case (s_q.st)
			ccac_pkg::ST_IDLE: begin
				if (CONV_DONE) begin
					s_d.smp = CONV;
					s_d.st = ccac_pkg::ST_CURRENT;
				end
			end
			ccac_pkg::ST_CURRENT: begin
				s_d.current = cur_prod[15:0];
				s_d.cur_ovf = (cur_prod[31:15] != {17{cur_prod[15]}});
				s_d.st = ccac_pkg::ST_POWER;
			end
			ccac_pkg::ST_POWER: begin
				s_d.power = pwr_quot[15:0];
				s_d.overflow = s_q.cur_ovf || (pwr_quot[31:16] != 16'h0000);
				// Highest select bit alone is compared
				if (s_q.sel[5]) begin
					limit_hit = $signed(s_q.smp.sense) > $signed(ALERT_LIMIT);
				end else if (s_q.sel[4]) begin
					limit_hit = $signed(s_q.smp.sense) < $signed(ALERT_LIMIT);
				end else if (s_q.sel[3]) begin
					limit_hit = s_q.smp.bus > ALERT_LIMIT;
				end else if (s_q.sel[2]) begin
					limit_hit = s_q.smp.bus < ALERT_LIMIT;
				end else if (s_q.sel[1]) begin
					limit_hit = pwr_quot > {16'h0000, ALERT_LIMIT};
				end
				if (s_q.latch) begin
					s_d.alert_src = s_d.alert_src || limit_hit;
				end else begin
					s_d.alert_src = limit_hit;
				end
				s_d.conv_ready = 1'b1;
				s_d.st = ccac_pkg::ST_IDLE;
			end
			default: begin
				s_d.st = ccac_pkg::ST_IDLE;
			end
		endcase

		// Open drain: drive low while the line must read low
		s_d.alert_oe = (s_d.alert_src || (s_d.sel[0] && s_d.conv_ready)) ^ s_d.polarity;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s_q.st <= ccac_pkg::ST_IDLE;
			s_q.smp <= '0;
			s_q.calib <= ccac_pkg::RST_CALIB;
			s_q.sel <= ccac_pkg::RST_SELECT;
			s_q.polarity <= 1'b0;
			s_q.latch <= 1'b0;
			s_q.alert_src <= 1'b0;
			s_q.conv_ready <= 1'b0;
			s_q.overflow <= 1'b0;
			s_q.cur_ovf <= 1'b0;
			s_q.current <= ccac_pkg::RST_CURRENT;
			s_q.power <= ccac_pkg::RST_POWER;
			s_q.rdata <= 16'h0000;
			s_q.alert_oe <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign REG_RDATA = s_q.rdata;
	assign POWER_RESULT = s_q.power;
	assign ALERT_O = 1'b0;
	assign ALERT_OE = s_q.alert_oe;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	sequence conv_start;
		CONV_DONE && (s_q.st == ccac_pkg::ST_IDLE);
	endsequence

	sequence pipe_walk;
		(s_q.st == ccac_pkg::ST_CURRENT) ##1 (s_q.st == ccac_pkg::ST_POWER);
	endsequence

	a_ready_after_math: assert property (
		conv_start |=> pipe_walk ##1 (s_q.conv_ready && s_q.st == ccac_pkg::ST_IDLE))
		else $error("conversion ready not set three cycles after a conversion");

	a_current_product: assert property (
		(s_q.st == ccac_pkg::ST_CURRENT) |=> (s_q.current == $past(cur_prod[15:0])))
		else $error("current result is not the product");

	a_current_sign: assert property (
		(s_q.st == ccac_pkg::ST_POWER) && !s_q.cur_ovf && (s_q.calib != 15'h0000)
		&& (s_q.smp.sense != 16'h0000)
		|-> (s_q.current[ccac_pkg::POS_SIGN] == s_q.smp.sense[15]))
		else $error("current sign differs from sense sign");

	a_calib_msb_zero: assert property (
		REQ.rd && (REQ.addr == ccac_pkg::ADDR_CALIB) |=> !REG_RDATA[15])
		else $error("calibration bit 15 read as one");

	a_reserved_zero: assert property (
		REQ.rd && (REQ.addr == ccac_pkg::ADDR_ALERT_CTL) |=> (REG_RDATA[9:5] == 5'h00))
		else $error("reserved control bits read as one");

	a_read_clears_ready: assert property (
		ctl_read && s_q.st != ccac_pkg::ST_POWER |=> !s_q.conv_ready)
		else $error("control read did not clear conversion ready");

	a_read_old_flags: assert property (
		ctl_read |=> (REG_RDATA[ccac_pkg::POS_CONV_READY] == $past(s_q.conv_ready)))
		else $error("control read did not return flags before clear");

	a_cfg_clears_ready: assert property (
		CFG_WR && !CFG_POWER_DOWN && s_q.st != ccac_pkg::ST_POWER |=> !s_q.conv_ready)
		else $error("configuration write did not clear conversion ready");

	a_latch_holds_flag: assert property (
		s_q.latch && s_q.alert_src && !ctl_read && !(REQ.wr && REQ.addr == ccac_pkg::ADDR_ALERT_CTL)
		|=> s_q.alert_src)
		else $error("latched alert source dropped without a read");

	a_transparent_follow: assert property (
		!s_q.latch && (s_q.st == ccac_pkg::ST_POWER) |=> (s_q.alert_src == $past(limit_hit)))
		else $error("transparent alert source does not follow the comparison");

	a_alert_polarity: assert property (
		##1 (ALERT_OE == ((s_q.alert_src || (s_q.sel[0] && s_q.conv_ready)) ^ s_q.polarity)))
		else $error("alert pin drive does not match flags and polarity");

	a_priority_sense: assert property (
		(s_q.st == ccac_pkg::ST_POWER) && s_q.sel[5] && !s_q.latch
		|=> (s_q.alert_src == ($signed($past(s_q.smp.sense)) > $signed($past(ALERT_LIMIT)))))
		else $error("sense over limit did not take priority");

	// ----------------------------------------
	// Limit selects below the top one, then power, overflow and register checks
	// ----------------------------------------
	sequence power_step_clean;
		(s_q.st == ccac_pkg::ST_POWER) && (pwr_quot[31:16] == 16'h0000);
	endsequence

	a_sense_under: assert property (
		(s_q.st == ccac_pkg::ST_POWER) && (s_q.sel[5:4] == 2'b01) && !s_q.latch
		|=> (s_q.alert_src == ($signed($past(s_q.smp.sense)) < $signed($past(ALERT_LIMIT)))))
		else $error("sense under limit comparison wrong");

	a_bus_over: assert property (
		(s_q.st == ccac_pkg::ST_POWER) && (s_q.sel[5:3] == 3'b001) && !s_q.latch
		|=> (s_q.alert_src == ($past(s_q.smp.bus) > $past(ALERT_LIMIT))))
		else $error("bus over limit comparison wrong");

	a_bus_under: assert property (
		(s_q.st == ccac_pkg::ST_POWER) && (s_q.sel[5:2] == 4'b0001) && !s_q.latch
		|=> (s_q.alert_src == ($past(s_q.smp.bus) < $past(ALERT_LIMIT))))
		else $error("bus under limit comparison wrong");

	a_power_over: assert property (
		power_step_clean ##0 ((s_q.sel[5:1] == 5'b00001) && !s_q.latch)
		|=> (s_q.alert_src == (POWER_RESULT > $past(ALERT_LIMIT))))
		else $error("power over limit comparison wrong");

	a_power_step: assert property (
		power_step_clean
		|=> ((32'(POWER_RESULT) * 32'(ccac_pkg::POWER_DIV)) <= $past(pwr_prod))
		&& ($past(pwr_prod) < ((32'(POWER_RESULT) + 32'h00000001) * 32'(ccac_pkg::POWER_DIV))))
		else $error("power result is not one step per twenty-five current steps");

	a_overflow_flag: assert property (
		(s_q.st == ccac_pkg::ST_POWER) && s_q.cur_ovf |=> s_q.overflow)
		else $error("current overflow did not set the overflow flag");

	a_sample_taken: assert property (
		conv_start |=> (s_q.smp == $past(CONV)))
		else $error("conversion result not sampled when done");

	a_calib_write: assert property (
		REQ.wr && (REQ.addr == ccac_pkg::ADDR_CALIB) |=> (s_q.calib == $past(REQ.wdata[14:0])))
		else $error("calibration write not taken as 15 bits");

	a_current_readonly: assert property (
		REQ.wr && (REQ.addr == ccac_pkg::ADDR_CURRENT) && (s_q.st != ccac_pkg::ST_CURRENT)
		|=> $stable(s_q.current))
		else $error("host write changed the current result");

	a_current_readback: assert property (
		REQ.rd && (REQ.addr == ccac_pkg::ADDR_CURRENT) |=> (REG_RDATA == $past(s_q.current)))
		else $error("current read did not return the latest result");

	// ----------------------------------------
	// Flag and pin origins
	// ----------------------------------------
	a_latch_sets: assert property (
		(s_q.st == ccac_pkg::ST_POWER) && s_q.latch && s_q.sel[5]
		&& ($signed(s_q.smp.sense) > $signed(ALERT_LIMIT)) |=> s_q.alert_src)
		else $error("latch mode did not set the alert source");

	a_ready_from_math: assert property (
		$rose(s_q.conv_ready) |-> ($past(s_q.st) == ccac_pkg::ST_POWER))
		else $error("conversion ready rose outside the power step");

	a_source_from_compare: assert property (
		$rose(s_q.alert_src) |-> ($past(s_q.st) == ccac_pkg::ST_POWER))
		else $error("alert source rose outside the compare step");

	a_ready_alert_pin: assert property (
		s_q.sel[0] && s_q.conv_ready |-> (ALERT_OE != s_q.polarity))
		else $error("ready alert did not drive the alert pin");

	a_limit_alert_pin: assert property (
		s_q.alert_src |-> (ALERT_OE != s_q.polarity))
		else $error("limit alert did not drive the alert pin");

endmodule

// ==== src/ccac_pkg.sv ====
// Package for the current-result and alert-control block.
// Assumes one system clock and a register port driven by the serial engine.
package ccac_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CURRENT = 8'h04;
	localparam logic [7:0] ADDR_CALIB = 8'h05;
	localparam logic [7:0] ADDR_ALERT_CTL = 8'h06;

	// ----------------------------------------
	// Field positions of the alert select and flags register
	// ----------------------------------------
	localparam int POS_SENSE_OVER = 15;
	localparam int POS_SENSE_UNDER = 14;
	localparam int POS_BUS_OVER = 13;
	localparam int POS_BUS_UNDER = 12;
	localparam int POS_POWER_OVER = 11;
	localparam int POS_READY_ALERT = 10;
	localparam int POS_ALERT_SRC = 4;
	localparam int POS_CONV_READY = 3;
	localparam int POS_OVERFLOW = 2;
	localparam int POS_POLARITY = 1;
	localparam int POS_LATCH = 0;
	localparam int POS_SIGN = 15;

	// ----------------------------------------
	// Reset values and scaling
	// ----------------------------------------
	localparam logic [15:0] RST_CURRENT = 16'h0000;
	localparam logic [14:0] RST_CALIB = 15'h0000;
	localparam logic [5:0] RST_SELECT = 6'h00;
	localparam logic [15:0] RST_POWER = 16'h0000;
	// Power weight is 25 current steps; bus step 1.25 mV gives this divider
	localparam int POWER_DIV = 20000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CURRENT = 2'b01,
		ST_POWER = 2'b10
	} ccac_state_e;

	// Results of one completed conversion from the converter engine
	typedef struct packed {
		logic [15:0] sense;
		logic [15:0] bus;
	} ccac_conv_s;

	// Register access from the serial engine
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} ccac_req_s;

endpackage

// ==== testbench/ccac_core_tb.sv ====
// Self-checking bench for the current result and alert control block.
// Assumes the host model in ccac_host and a 100 MHz clock.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module ccac_core_tb;
	logic CLK, NRST, CONV_DONE, CFG_WR, CFG_POWER_DOWN, ALERT_O, ALERT_OE;
	ccac_pkg::ccac_req_s REQ;
	ccac_pkg::ccac_conv_s CONV;
	logic [15:0] REG_RDATA, ALERT_LIMIT, POWER_RESULT, rd_v, cal, cur, pw, w;
	logic [5:0] sel;
	logic pol, lat, src, rdy, ovf;
	logic [7:0] adr [4] = '{8'h04, 8'h05, 8'h06, 8'h07};
	int checks, err_total;
	ccac_core DUT (.CLK(CLK), .NRST(NRST), .REQ(REQ), .REG_RDATA(REG_RDATA), .CONV_DONE(CONV_DONE),
		.CONV(CONV), .ALERT_LIMIT(ALERT_LIMIT), .CFG_WR(CFG_WR), .CFG_POWER_DOWN(CFG_POWER_DOWN),
		.POWER_RESULT(POWER_RESULT), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE));
	ccac_host host (.CLK(CLK), .RDATA(REG_RDATA), .REQ(REQ));
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	function automatic logic cmp_f(input logic [5:0] m, input logic [15:0] s, b, l,
		input logic [31:0] p);
		if (m[5]) return $signed(s) > $signed(l);
		if (m[4]) return $signed(s) < $signed(l);
		if (m[3]) return b > l;
		if (m[2]) return b < l;
		if (m[1]) return p > {16'h0000, l};
		return 1'b0;
	endfunction
	task automatic conv(input logic [15:0] s, b, l);
		logic signed [31:0] p;
		logic [31:0] a;
		@(posedge CLK);
		CONV <= '{sense: s, bus: b};
		ALERT_LIMIT <= l;
		CONV_DONE <= 1'b1;
		@(posedge CLK);
		CONV_DONE <= 1'b0;
		repeat (3) @(posedge CLK);
		#1;
		p = $signed(s) * $signed({17'h00000, cal[14:0]});
		ovf = (p > 32767) || (p < -32768);
		cur = p[15:0];
		a = cur[15] ? {16'h0000, -cur} : {16'h0000, cur};
		a = a * b / ccac_pkg::POWER_DIV;
		pw = a[15:0];
		ovf = ovf || (a[31:16] != 16'h0000);
		src = cmp_f(sel, s, b, l, a) | (lat & src);
		rdy = 1'b1;
	endtask
	task automatic set_ctl(input logic [15:0] v);
		host.wr(ccac_pkg::ADDR_ALERT_CTL, v);
		{sel, pol, lat} = {v[15:10], v[1:0]};
	endtask
	task automatic set_cal(input logic [15:0] v);
		host.wr(ccac_pkg::ADDR_CALIB, v);
		cal = {1'b0, v[14:0]};
		host.rd(ccac_pkg::ADDR_CALIB, rd_v);
		`CHK(rd_v, cal)
	endtask
	task automatic check_all();
		`CHK(POWER_RESULT, pw)
		`CHK(ALERT_OE, (src | (sel[0] & rdy)) ^ pol)
		host.rd(ccac_pkg::ADDR_CURRENT, rd_v);
		`CHK(rd_v, cur)
		host.rd(ccac_pkg::ADDR_ALERT_CTL, rd_v);
		`CHK(rd_v, {sel, 5'h00, src, rdy, ovf, pol, lat})
		rdy = 1'b0;
		if (lat) src = 1'b0;
		`CHK(ALERT_OE, (src | (sel[0] & rdy)) ^ pol)
	endtask
	task automatic cfg(input logic pd);
		@(posedge CLK);
		CFG_WR <= 1'b1;
		CFG_POWER_DOWN <= pd;
		@(posedge CLK);
		CFG_WR <= 1'b0;
		@(posedge CLK);
		#1;
		if (!pd) rdy = 1'b0;
		`CHK(ALERT_OE, (src | (sel[0] & rdy)) ^ pol)
	endtask
	task automatic end_of_test();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		err_total++;
		end_of_test();
	end
	initial begin
		{NRST, CONV_DONE, CFG_WR, CFG_POWER_DOWN, sel, pol, lat, src, rdy, ovf} = '0;
		CONV = '0;
		ALERT_LIMIT = 16'h0000;
		cal = 16'h0000;
		checks = 0;
		err_total = 0;
		rd_v = 16'($urandom(32'h9ADA3FF1));
		repeat (10) @(posedge CLK);
		NRST <= 1'b1;
		#1;
		`CHK({ALERT_O, ALERT_OE, POWER_RESULT}, 18'h00000)
		foreach (adr[i]) begin
			host.rd(adr[i], rd_v);
			`CHK(rd_v, 16'h0000)
		end
		host.wr(ccac_pkg::ADDR_CURRENT, 16'hFFFF);
		set_ctl(16'h03FC);
		host.rd(ccac_pkg::ADDR_ALERT_CTL, rd_v);
		`CHK(rd_v, 16'h0000)
		host.rd(ccac_pkg::ADDR_CURRENT, rd_v);
		`CHK(rd_v, 16'h0000)
		set_cal(16'hFFFF);
		conv(16'hFFFF, 16'h1000, 16'h0000);
		check_all();
		set_cal(16'h0002);
		conv(16'h7FFF, 16'h0100, 16'h0000);
		check_all();
		set_cal(16'h0003);
		for (int i = 0; i < 5; i++) begin
			set_ctl({6'h3E >> i, 10'h000});
			conv(16'($urandom % 32'h00000200), 16'h0100, 16'h0180);
			check_all();
		end
		set_ctl(16'h0400);
		conv(16'h0010, 16'h0200, 16'h0000);
		cfg(1'b1);
		cfg(1'b0);
		check_all();
		set_cal(16'h0001);
		set_ctl(16'h0800);
		conv(16'h8000, 16'hFFFF, 16'hF000);
		check_all();
		for (int m = 0; m < 2; m++) begin
			set_ctl(16'h8000 | 16'(m));
			conv(16'h0064, 16'h0100, 16'h0032);
			conv(16'h000A, 16'h0100, 16'h0032);
			check_all();
		end
		repeat (30) begin
			w = 16'($urandom);
			set_cal({w[15], 7'h00, w[7:0]});
			set_ctl(16'($urandom));
			w = 16'($urandom);
			conv({{8{w[7]}}, w[7:0]}, {1'b0, w[15:1]}, 16'($urandom));
			check_all();
		end
		end_of_test();
	end
endmodule

// ==== testbench/ccac_host.sv ====
// Host model driving the register port of the current and alert block.
// Assumes the bench calls its tasks from one process, on CLK.
`timescale 1ns/1ps
module ccac_host (
	input wire logic CLK,
	input wire logic [15:0] RDATA,
	output ccac_pkg::ccac_req_s REQ
);
	initial REQ = '0;
	// One-cycle write strobe, data held with it
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge CLK);
		REQ <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge CLK);
		REQ.wr <= 1'b0;
	endtask
	// Data is registered on the taking edge and read 1 ns after it
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge CLK);
		REQ <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
		@(posedge CLK);
		REQ.rd <= 1'b0;
		#1;
		d = RDATA;
	endtask
endmodule
